// ---- hw/nvsc_pkg.sv ----
// Constants for the host-side controller of a byte-wide non-volatile SRAM.
// Assumes a 125 MHz system clock and a device wired straight to the pins.
// Notes on behaviour
// RULE1 - Full 19-bit byte address selects one byte
// RULE2 - One shared 8-bit bidirectional data bus
// RULE3 - Chip select low for every access
// RULE4 - Write strobe stores byte at latched address
// RULE5 - Device drives data only while output enable low
// RULE6 - Output enable high releases data bus
// RULE7 - Busy line low during save or power-up
// RULE8 - Host pulling busy line low requests save
// RULE9 - Busy line rests high through weak pull-up
// RULE10 - Power loss triggers automatic save
// RULE11 - Power-up restores array automatically
// RULE12 - Host may start save and restore itself; this host starts only a save, through save_req
// RULE13 - Host waits while busy line is low
package nvsc_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  // Access timing: one access cycle of 45 ns, the slowest grade
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACCESS_NS = 45;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least low time of the store request pulse on the busy line
  localparam int REQ_PULSE_NS = 100;
  localparam int REQ_PULSE_CYC = (REQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Wait after the request before the device is trusted to show busy
  localparam int BUSY_SETTLE_CYC = 4;
  localparam int CNT_W = 8;
  typedef enum logic [2:0] {
    NVSC_IDLE = 3'b000,
    NVSC_SETUP = 3'b001,
    NVSC_STROBE = 3'b011,
    NVSC_HOLD = 3'b010,
    NVSC_REQ = 3'b110,
    NVSC_SETTLE = 3'b111,
    NVSC_WAIT = 3'b101
  } nvsc_state_t;
endpackage

// ---- hw/nvsc_sync3.sv ----
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/1ps
module nvsc_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  always_comb
  begin
    next_level = level;
    // Change counts only once the second and third stages agree
    if (s2 == s3)
    begin
      next_level = s3;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      level <= RST_VAL;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule // nvsc_sync3

// ---- hw/nvsc_host.sv ----
// Host controller that drives a byte-wide non-volatile SRAM through its pins.
// Assumes the user holds a request until it sees req_ready; one access at a time.
`timescale 1ns/1ps
module nvsc_host #(
  parameter int ACCESS_CYC = nvsc_pkg::ACCESS_CYC,
  parameter int REQ_PULSE_CYC = nvsc_pkg::REQ_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [nvsc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [nvsc_pkg::DATA_W-1:0] req_wdata,
  input wire logic save_req,
  output logic req_ready,
  output logic done,
  output logic [nvsc_pkg::DATA_W-1:0] rdata,
  output logic dev_busy,
  output logic [nvsc_pkg::ADDR_W-1:0] byte_loc_bus,
  output logic chip_sel_n,
  output logic write_n,
  output logic out_en_n,
  input wire logic [nvsc_pkg::DATA_W-1:0] byte_lanes_in,
  output logic [nvsc_pkg::DATA_W-1:0] byte_lanes_out,
  output logic byte_lanes_oe,
  input wire logic nv_save_busy_n_in,
  output logic nv_save_busy_n_out,
  output logic nv_save_busy_n_oe
);
  // =====================================================
  // Pin inputs
  logic busy_n_sync;
  logic [nvsc_pkg::DATA_W-1:0] lanes_sync;

  // Starts as busy: a restore may already run when reset ends, so the
  // pin is trusted as idle only once the stages have seen it high
  nvsc_sync3 #(.RST_VAL(1'b0)) u_busy_sync ( // RULE9 RULE11
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(nv_save_busy_n_in),
    .level(busy_n_sync)
  );

  // Data is sampled only at the end of a long access, so the bus is stable
  genvar gi;
  generate
    for (gi = 0; gi < nvsc_pkg::DATA_W; gi++)
    begin : g_lane
      nvsc_sync3 #(.RST_VAL(1'b0)) u_lane_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(byte_lanes_in[gi]),
        .level(lanes_sync[gi])
      );
    end
  endgenerate

  // =====================================================
  // Access sequencer
  nvsc_pkg::nvsc_state_t state;
  nvsc_pkg::nvsc_state_t next_state;
  logic [nvsc_pkg::CNT_W-1:0] cnt;
  logic [nvsc_pkg::CNT_W-1:0] next_cnt;
  logic is_write;
  logic next_is_write;
  logic next_req_ready;
  logic next_done;
  logic [nvsc_pkg::DATA_W-1:0] next_rdata;
  logic [nvsc_pkg::ADDR_W-1:0] next_addr;
  logic next_cs_n;
  logic next_we_n;
  logic next_oe_n;
  logic [nvsc_pkg::DATA_W-1:0] next_lanes_out;
  logic next_lanes_oe;
  logic next_busy_oe;
  logic next_dev_busy;

  // Latch-off count: wait for the access time and the pin lag
  localparam logic [nvsc_pkg::CNT_W-1:0] ACC_LAST = nvsc_pkg::CNT_W'(ACCESS_CYC + 3);
  localparam logic [nvsc_pkg::CNT_W-1:0] REQ_LAST = nvsc_pkg::CNT_W'(REQ_PULSE_CYC - 1);
  localparam logic [nvsc_pkg::CNT_W-1:0] SET_LAST = nvsc_pkg::CNT_W'(nvsc_pkg::BUSY_SETTLE_CYC - 1);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_is_write = is_write;
    next_req_ready = 1'b0;
    next_done = 1'b0;
    next_rdata = rdata;
    next_addr = byte_loc_bus;
    next_cs_n = chip_sel_n;
    next_we_n = write_n;
    next_oe_n = out_en_n;
    next_lanes_out = byte_lanes_out;
    next_lanes_oe = byte_lanes_oe;
    next_busy_oe = nv_save_busy_n_oe;
    next_dev_busy = !busy_n_sync; // RULE7
    case (state)
      nvsc_pkg::NVSC_IDLE:
      begin
        next_cnt = '0;
        // Busy device blocks everything; covers power-up restore too
        if (busy_n_sync) // RULE13 RULE11 RULE7
        begin
          if (save_req) // RULE12 RULE8
          begin
            next_busy_oe = 1'b1;
            next_req_ready = 1'b1;
            next_state = nvsc_pkg::NVSC_REQ;
          end
          else if (req_valid)
          begin
            next_req_ready = 1'b1;
            next_is_write = req_write;
            next_addr = req_addr; // RULE1
            next_lanes_out = req_wdata;
            next_cs_n = 1'b0; // RULE3
            next_state = nvsc_pkg::NVSC_SETUP;
          end
        end
      end
      nvsc_pkg::NVSC_SETUP:
      begin
        // Address is latched by the device at the select edge, then strobes
        if (is_write)
        begin
          next_we_n = 1'b0; // RULE4
          next_lanes_oe = 1'b1; // RULE2
        end
        else
        begin
          next_oe_n = 1'b0; // RULE5
        end
        next_state = nvsc_pkg::NVSC_STROBE;
      end
      nvsc_pkg::NVSC_STROBE:
      begin
        next_cnt = cnt + 1'b1;
        if (cnt == ACC_LAST)
        begin
          if (!is_write)
          begin
            next_rdata = lanes_sync;
          end
          next_we_n = 1'b1;
          next_oe_n = 1'b1; // RULE6
          next_state = nvsc_pkg::NVSC_HOLD;
        end
      end
      nvsc_pkg::NVSC_HOLD:
      begin
        // Data held one cycle past the write strobe rising edge
        next_cs_n = 1'b1;
        next_lanes_oe = 1'b0;
        next_done = 1'b1;
        next_state = nvsc_pkg::NVSC_IDLE;
      end
      nvsc_pkg::NVSC_REQ:
      begin
        next_cnt = cnt + 1'b1;
        if (cnt == REQ_LAST)
        begin
          next_busy_oe = 1'b0;
          next_cnt = '0;
          next_state = nvsc_pkg::NVSC_SETTLE;
        end
      end
      nvsc_pkg::NVSC_SETTLE:
      begin
        next_cnt = cnt + 1'b1;
        if (cnt == SET_LAST)
        begin
          next_state = nvsc_pkg::NVSC_WAIT;
        end
      end
      nvsc_pkg::NVSC_WAIT:
      begin
        // Save is timed by the device; wait for busy release
        if (busy_n_sync) // RULE13 RULE10
        begin
          next_done = 1'b1;
          next_state = nvsc_pkg::NVSC_IDLE;
        end
      end
      default:
      begin
        next_state = nvsc_pkg::NVSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= nvsc_pkg::NVSC_IDLE;
      cnt <= '0;
      is_write <= 1'b0;
      req_ready <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      byte_loc_bus <= '0;
      chip_sel_n <= 1'b1;
      write_n <= 1'b1;
      out_en_n <= 1'b1;
      byte_lanes_out <= '0;
      byte_lanes_oe <= 1'b0;
      nv_save_busy_n_oe <= 1'b0;
      dev_busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      is_write <= next_is_write;
      req_ready <= next_req_ready;
      done <= next_done;
      rdata <= next_rdata;
      byte_loc_bus <= next_addr;
      chip_sel_n <= next_cs_n;
      write_n <= next_we_n;
      out_en_n <= next_oe_n;
      byte_lanes_out <= next_lanes_out;
      byte_lanes_oe <= next_lanes_oe;
      nv_save_busy_n_oe <= next_busy_oe;
      dev_busy <= next_dev_busy;
    end
  end

  // Open-drain request: only ever drives low
  assign nv_save_busy_n_out = 1'b0; // RULE8

  // =====================================================
  // Checks
  property p_oe_excl;
    @(posedge clk_sys) disable iff (rst)
    !(byte_lanes_oe && !out_en_n);
  endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("host and device drive bus together"); // RULE2

  property p_cs_strobe;
    @(posedge clk_sys) disable iff (rst)
    (!write_n || !out_en_n) |-> !chip_sel_n;
  endproperty
  a_cs_strobe: assert property (p_cs_strobe) else $error("strobe without chip select"); // RULE3

  property p_addr_stable;
    @(posedge clk_sys) disable iff (rst)
    (!chip_sel_n && $past(!chip_sel_n)) |-> $stable(byte_loc_bus);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved during access"); // RULE1

  property p_we_data;
    @(posedge clk_sys) disable iff (rst)
    !write_n |-> byte_lanes_oe && $stable(byte_lanes_out);
  endproperty
  a_we_data: assert property (p_we_data) else $error("write data not held under strobe"); // RULE4

  property p_oe_release;
    @(posedge clk_sys) disable iff (rst)
    $rose(out_en_n) |=> chip_sel_n && !byte_lanes_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("bus not idle after read"); // RULE6

  property p_no_acc_busy;
    @(posedge clk_sys) disable iff (rst)
    $fell(chip_sel_n) |-> $past(busy_n_sync);
  endproperty
  a_no_acc_busy: assert property (p_no_acc_busy) else $error("access started while busy"); // RULE13

  property p_req_pulse;
    @(posedge clk_sys) disable iff (rst)
    $rose(nv_save_busy_n_oe) |-> nv_save_busy_n_oe [*8];
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("save request pulse too short"); // RULE8

  property p_req_no_access;
    @(posedge clk_sys) disable iff (rst)
    nv_save_busy_n_oe |-> chip_sel_n;
  endproperty
  a_req_no_access: assert property (p_req_no_access) else $error("access during save request"); // RULE12

  property p_read_len;
    @(posedge clk_sys) disable iff (rst)
    $fell(out_en_n) |-> !out_en_n [*8];
  endproperty
  a_read_len: assert property (p_read_len) else $error("read strobe too short"); // RULE5
endmodule // nvsc_host

// ---- testbench/nvsc_dev_model.sv ----
// Behavioural model of the byte-wide non-volatile SRAM seen from its pins.
// Assumes the bench resolves the shared data lines and the pulled-up busy line.
`timescale 1ns/1ps
module nvsc_dev_model #(
  parameter int PWR_CYC = 30,
  parameter int SAVE_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [nvsc_pkg::ADDR_W-1:0] byte_loc_bus,
  input wire logic chip_sel_n,
  input wire logic write_n,
  input wire logic out_en_n,
  input wire logic [nvsc_pkg::DATA_W-1:0] byte_lanes,
  output logic [nvsc_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic busy_pin,
  output logic busy_oe
);
  logic [7:0] mem [0:524287];
  logic [18:0] lat = '0;
  int cnt = 0;
  int saves = 0;
  bit pend = 0;
  // ==========================================
  // Array access
  always @(negedge chip_sel_n)
  begin
    #1;
    lat = byte_loc_bus;
  end
  always @(posedge write_n)
    if (!chip_sel_n)
      mem[lat] = byte_lanes;
  assign dq_oe = !chip_sel_n && !out_en_n && write_n;
  assign dq_out = mem[lat];
  // ==========================================
  // Busy line: power-up restore, then saves on request
  assign busy_oe = cnt != 0;
  always @(posedge clk_sys)
    if (rst)
    begin
      cnt <= PWR_CYC;
      mem[0] = 8'h3c;
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
    else if (!busy_pin)
      pend <= 1'b1;
    else if (pend)
    begin
      pend <= 1'b0;
      cnt <= SAVE_CYC;
      saves <= saves + 1;
    end
endmodule // nvsc_dev_model

// ---- testbench/nvsram_async_port_tb.sv ----
// Self-checking bench for the host controller against the device model.
// Assumes the default access and pulse lengths of the controller.
`timescale 1ns/1ps
module nvsram_async_port_tb;
  logic clk_sys = 0, rst = 1, req_valid = 0, req_write = 0, save_req = 0;
  logic [nvsc_pkg::ADDR_W-1:0] req_addr = '0, addr_bus;
  logic [nvsc_pkg::DATA_W-1:0] req_wdata = '0, rdata, h_out, d_out;
  logic req_ready, done, dev_busy, chip_sel_n, write_n, out_en_n, h_oe, d_oe, b_oe_h, b_oe_d, b_out;
  int mismatches = 0, samples_checked = 0;
  // ==========================================
  // Pin resolution; released data lines show an inverted stale value
  wire logic [7:0] lanes = h_oe ? h_out : d_oe ? d_out : 8'hff ^ d_out;
  wire logic busy_pin = (b_oe_h || b_oe_d) ? 1'b0 : 1'b1;
  always #4 clk_sys = ~clk_sys;
  nvsc_host DUT (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .save_req(save_req), .req_ready(req_ready),
    .done(done), .rdata(rdata), .dev_busy(dev_busy), .byte_loc_bus(addr_bus), .chip_sel_n(chip_sel_n),
    .write_n(write_n), .out_en_n(out_en_n), .byte_lanes_in(lanes), .byte_lanes_out(h_out),
    .byte_lanes_oe(h_oe), .nv_save_busy_n_in(busy_pin), .nv_save_busy_n_out(b_out),
    .nv_save_busy_n_oe(b_oe_h));
  nvsc_dev_model m (.clk_sys(clk_sys), .rst(rst), .byte_loc_bus(addr_bus), .chip_sel_n(chip_sel_n),
    .write_n(write_n), .out_en_n(out_en_n), .byte_lanes(lanes), .dq_out(d_out), .dq_oe(d_oe),
    .busy_pin(busy_pin), .busy_oe(b_oe_d));
  // ==========================================
  // Shared tasks
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_hi(bit on_done, output int n);
    n = 0;
    while ((on_done ? done : req_ready) !== 1'b1)
    begin
      step(1);
      n++;
      if (n > 400)
      begin
        mismatches++;
        $display("mismatch handshake expected 1 seen 0");
        summarize();
      end
    end
  endtask
  task automatic access(bit wr, logic [18:0] a, logic [7:0] d, output logic [7:0] q, output int n);
    int k;
    req_valid = 1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    wait_hi(0, n);
    chk("chip_sel_n", chip_sel_n, 0);
    chk("byte_loc_bus", addr_bus, a);
    req_valid = 0;
    step(2);
    chk("byte_lanes_oe", h_oe, wr);
    chk("strobe", wr ? write_n : out_en_n, 0);
    chk("device drives", d_oe, !wr);
    wait_hi(1, k);
    chk("released", {out_en_n, h_oe, d_oe}, 3'b100);
    q = rdata;
    step(1);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_powerup();
    logic [7:0] q;
    int n;
    step(10);
    chk("dev_busy", dev_busy, 1);
    access(0, 19'h00000, 8'h00, q, n);
    chk("held off", n + 10 >= 30, 1);
    chk("restored", q, 8'h3c);
    $display("test powerup done");
  endtask
  task automatic t_rw();
    logic [18:0] a[4] = '{19'h00000, 19'h7ffff, 19'h3ffff, 19'h00001};
    logic [7:0] d[4] = '{8'ha5, 8'h5a, 8'h0f, 8'hf0};
    logic [7:0] q;
    int n;
    foreach (a[i]) access(1, a[i], d[i], q, n);
    foreach (a[i])
    begin
      access(0, a[i], 8'h00, q, n);
      chk("rdata", q, d[i]);
    end
    $display("test read write done");
  endtask
  task automatic t_save();
    logic [7:0] q;
    int n;
    chk("idle busy pin", busy_pin, 1);
    save_req = 1;
    wait_hi(0, n);
    chk("pull busy", {b_oe_h, b_out, busy_pin}, 3'b100);
    save_req = 0;
    wait_hi(1, n);
    chk("saves", m.saves, 1);
    chk("busy after save", {busy_pin, dev_busy}, 2'b10);
    access(0, 19'h7ffff, 8'h00, q, n);
    chk("rdata after save", q, 8'h5a);
    $display("test save done");
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 0;
    t_powerup();
    t_rw();
    t_save();
    summarize();
  end
endmodule // nvsram_async_port_tb
